// ---- common/pwr_seq_pkg.sv ----
// constants and state encodings for the standby, wake and boot sequencer
package pwr_seq_pkg;
    // input clock rate
    localparam int CLK_HZ = 25000000;
    // boot copy timing
    localparam int BOOT_FIXED_US = 2000;
    localparam int BOOT_PER_KB_US = 3600;
    localparam int BOOT_FIXED_CYC = (CLK_HZ / 1000) * BOOT_FIXED_US / 1000;
    localparam int BOOT_PER_KB_CYC = (CLK_HZ / 1000) * BOOT_PER_KB_US / 1000;
    // image geometry and port widths
    localparam int RAM_BYTES = 4096;
    localparam int RAM_AW = 12;
    localparam int KB_BYTES = 1024;
    localparam int RET_BYTES = 8;
    localparam int RET_AW = 3;
    localparam int GPIO_N = 9;
    localparam int PERIPH_N = 8;
    localparam int DIV_W = 3;
    localparam int TIMER_W = 32;
    // cycles the crystal is allowed before correction is taken as done
    localparam int XTAL_CAL_CYC = 1000;
    // reset values
    localparam logic [DIV_W-1:0] DIV_RST = 3'h0;
    localparam logic [TIMER_W-1:0] TIMER_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_BOOT_WAIT = 3'b001,
        ST_BOOT_COPY = 3'b010,
        ST_RUN = 3'b011,
        ST_XTAL_CAL = 3'b100,
        ST_TX = 3'b101
    } seq_state_t;
endpackage

// ---- dv/nvm_boot_model.sv ----
// boot memory model answering image reads within the read cycle
`timescale 1ns/1ps
`default_nettype none
module nvm_boot_model (
    input wire logic clk,
    input wire logic rd,
    input wire logic [11:0] addr,
    output logic [7:0] data
);
    // byte valid while a read stands, so the edge after it takes it; scrambled otherwise
    always_comb begin
        if (rd) begin
            data = addr[7:0] ^ 8'h5A;
        end else begin
            data = ~(addr[7:0] ^ 8'h5A);
        end
    end
endmodule
`default_nettype wire

// ---- dv/seq_sva.sv ----
// assertion checker for the standby wake boot sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_sva (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic LOW_POWER_OSC_EN,
    input wire logic CPU_RUN_EN,
    input wire logic BOOT_DONE,
    input wire logic NVM_RD,
    input wire logic [pwr_seq_pkg::RAM_AW-1:0] NVM_ADDR,
    input wire logic RAM_WE,
    input wire logic [pwr_seq_pkg::RAM_AW-1:0] RAM_ADDR,
    input wire logic TIMER_TICK,
    input wire logic XTAL_EN,
    input wire logic CARRIER_OSC_EN,
    input wire logic DIVIDER_EN,
    input wire logic PA_EN,
    input wire logic ANALOG_BUSY,
    input wire logic BANDGAP_EN,
    input wire logic [pwr_seq_pkg::PERIPH_N-1:0] PERIPH_OFF,
    input wire logic [pwr_seq_pkg::PERIPH_N-1:0] PERIPH_PWR
);
    logic [31:0] xc_q;
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    // counts cycles the crystal stays on
    always_ff @(posedge MCLK) begin
        if (SRST) xc_q <= 32'h0;
        else xc_q <= XTAL_EN ? xc_q + 32'h1 : 32'h0;
    end
    a_reset_idle: assert property ($fell(SRST) |-> !LOW_POWER_OSC_EN && !CPU_RUN_EN)
        else $error("awake after reset");
    a_standby_off: assert property (!LOW_POWER_OSC_EN |-> PERIPH_PWR == '0 && !CPU_RUN_EN)
        else $error("power in standby");
    a_run_booted: assert property (CPU_RUN_EN |-> LOW_POWER_OSC_EN && BOOT_DONE)
        else $error("cpu runs early");
    a_copy_halts: assert property (NVM_RD |-> !CPU_RUN_EN && !BOOT_DONE)
        else $error("cpu during copy");
    a_ram_pair: assert property (NVM_RD |=> RAM_WE && RAM_ADDR == $past(NVM_ADDR))
        else $error("copy pair");
    a_tick_osc: assert property (TIMER_TICK == LOW_POWER_OSC_EN)
        else $error("timer clock gating");
    a_xtal_len: assert property ($fell(XTAL_EN) |-> xc_q == pwr_seq_pkg::XTAL_CAL_CYC)
        else $error("xtal time");
    a_xtal_pa: assert property (PA_EN |-> !XTAL_EN) else $error("xtal on in tx");
    // carrier first, divider two cycles later, amplifier one cycle after that
    a_tx_stage: assert property ($rose(CARRIER_OSC_EN) |-> !DIVIDER_EN ##1 !DIVIDER_EN ##1 DIVIDER_EN && !PA_EN
        ##1 PA_EN) else $error("tx power order");
    a_periph_map: assert property (LOW_POWER_OSC_EN && $past(LOW_POWER_OSC_EN)
        |-> PERIPH_PWR == ~$past(PERIPH_OFF)) else $error("periph power");
    a_bandgap_off: assert property (!$past(ANALOG_BUSY) && !$past(XTAL_EN) && !XTAL_EN
        && !$past(CARRIER_OSC_EN) && !CARRIER_OSC_EN |-> !BANDGAP_EN) else $error("bandgap on");
    c_boot: cover property ($rose(CPU_RUN_EN));
    c_copy: cover property (RAM_WE);
    c_tx: cover property ($rose(PA_EN));
endmodule
bind standby_wake_boot_sequencer seq_sva chk (.MCLK(MCLK), .SRST(SRST), .LOW_POWER_OSC_EN(LOW_POWER_OSC_EN),
    .CPU_RUN_EN(CPU_RUN_EN), .BOOT_DONE(BOOT_DONE), .NVM_RD(NVM_RD), .NVM_ADDR(NVM_ADDR), .RAM_WE(RAM_WE),
    .RAM_ADDR(RAM_ADDR), .TIMER_TICK(TIMER_TICK), .XTAL_EN(XTAL_EN), .CARRIER_OSC_EN(CARRIER_OSC_EN),
    .DIVIDER_EN(DIVIDER_EN), .PA_EN(PA_EN), .ANALOG_BUSY(ANALOG_BUSY), .BANDGAP_EN(BANDGAP_EN),
    .PERIPH_OFF(PERIPH_OFF), .PERIPH_PWR(PERIPH_PWR));
`default_nettype wire

// ---- dv/standby_wake_boot_sequencer_tb_top.sv ----
// self-checking bench for the standby wake boot sequencer
`timescale 1ns/1ps
`default_nettype none
module standby_wake_boot_sequencer_tb_top;
    logic MCLK, SRST, SLEEP_EN, STANDBY_REQ, NVM_RD, RAM_WE, CPU_RUN_EN, BOOT_DONE, SYS_CLK_EN, LOW_POWER_OSC_EN;
    logic TIMER_TICK, XTAL_USE, TX_REQ, TX_END, XTAL_EN, CARRIER_CAL, CARRIER_OSC_EN, DIVIDER_EN, PA_EN;
    logic ANALOG_BUSY, BANDGAP_EN, WAKE_BY_TIMER, RET_WE;
    logic [pwr_seq_pkg::GPIO_N-1:0] GPIO_IN;
    logic [31:0] SLEEP_TICKS;
    logic [2:0] IMAGE_KB, CLK_DIV_SEL, RET_ADDR;
    logic [11:0] NVM_ADDR, RAM_ADDR;
    logic [7:0] NVM_DATA, RAM_WDATA, RET_WDATA, RET_RDATA, PERIPH_OFF, PERIPH_PWR;
    logic [7:0] ret [8];
    int seed = 26008;
    int n_mismatch = 0;
    int checked = 0;
    int i, n;
    standby_wake_boot_sequencer dut (.MCLK(MCLK), .SRST(SRST), .GPIO_IN(GPIO_IN), .SLEEP_TICKS(SLEEP_TICKS),
        .SLEEP_EN(SLEEP_EN), .STANDBY_REQ(STANDBY_REQ), .IMAGE_KB(IMAGE_KB), .NVM_ADDR(NVM_ADDR), .NVM_RD(NVM_RD),
        .NVM_DATA(NVM_DATA), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA), .RAM_WE(RAM_WE), .CPU_RUN_EN(CPU_RUN_EN),
        .BOOT_DONE(BOOT_DONE), .CLK_DIV_SEL(CLK_DIV_SEL), .SYS_CLK_EN(SYS_CLK_EN),
        .LOW_POWER_OSC_EN(LOW_POWER_OSC_EN),
        .TIMER_TICK(TIMER_TICK), .XTAL_USE(XTAL_USE), .TX_REQ(TX_REQ), .TX_END(TX_END), .XTAL_EN(XTAL_EN),
        .CARRIER_CAL(CARRIER_CAL), .CARRIER_OSC_EN(CARRIER_OSC_EN), .DIVIDER_EN(DIVIDER_EN), .PA_EN(PA_EN),
        .PERIPH_OFF(PERIPH_OFF), .PERIPH_PWR(PERIPH_PWR), .ANALOG_BUSY(ANALOG_BUSY), .BANDGAP_EN(BANDGAP_EN),
        .WAKE_BY_TIMER(WAKE_BY_TIMER), .RET_WE(RET_WE), .RET_ADDR(RET_ADDR), .RET_WDATA(RET_WDATA),
        .RET_RDATA(RET_RDATA));
    nvm_boot_model nvm (.clk(MCLK), .rd(NVM_RD), .addr(NVM_ADDR), .data(NVM_DATA));
    // free running clock
    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task summarize;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [7:0] img(input logic [11:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    task automatic clk(input int k);
        repeat (k) @(posedge MCLK);
    endtask
    task rst;
        @(posedge MCLK) SRST <= 1'b1;
        clk(5);
        SRST <= 1'b0;
        clk(3);
    endtask
    // main sequence
    initial begin
        SRST = 1'b1; GPIO_IN = '1; SLEEP_TICKS = 32'h0; SLEEP_EN = 1'b0; STANDBY_REQ = 1'b0; IMAGE_KB = 3'h1;
        CLK_DIV_SEL = 3'h0; XTAL_USE = 1'b1; TX_REQ = 1'b0; TX_END = 1'b0; PERIPH_OFF = 8'h00;
        ANALOG_BUSY = 1'b0; RET_WE = 1'b0; RET_ADDR = 3'h0; RET_WDATA = 8'h00;
        rst;
        @(negedge MCLK) chk("osc", LOW_POWER_OSC_EN, 0);
        chk("cpu", CPU_RUN_EN, 0);
        for (i = 0; i < 8; i++) begin
            @(posedge MCLK) ret[i] = 8'($random(seed));
            RET_WE <= 1'b1; RET_ADDR <= 3'(i); RET_WDATA <= ret[i];
        end
        @(posedge MCLK) RET_WE <= 1'b0;
        GPIO_IN[$unsigned($random(seed)) % 9] <= 1'b0;
        for (i = 0; i < 10 && NVM_RD !== 1'b1; i++) @(negedge MCLK);
        chk("nvm_rd", NVM_RD, 1);
        chk("nvm_addr", NVM_ADDR, 0);
        chk("by_pin", WAKE_BY_TIMER, 0);
        chk("booting", BOOT_DONE, 0);
        for (n = 0; n < 16; n++) begin
            @(negedge MCLK) chk("ram_we", RAM_WE, 1);
            chk("ram_addr", RAM_ADDR, n);
            chk("ram_data", RAM_WDATA, img(12'(n)));
            @(negedge MCLK) chk("cpu", CPU_RUN_EN, 0);
        end
        $display("test pin wake done");
        @(posedge MCLK) GPIO_IN <= '1;
        rst;
        @(negedge MCLK) chk("osc", LOW_POWER_OSC_EN, 0);
        @(posedge MCLK) IMAGE_KB <= 3'h0;
        SLEEP_EN <= 1'b1;
        SLEEP_TICKS <= 20 + $unsigned($random(seed)) % 40;
        for (i = 0; i < 200 && LOW_POWER_OSC_EN !== 1'b1; i++) @(negedge MCLK);
        chk("wake", LOW_POWER_OSC_EN, 1);
        for (n = 0; n < 60000 && CPU_RUN_EN !== 1'b1; n++) @(negedge MCLK);
        chk("boot_len", 32'(n >= 49999 && n <= 50004), 1);
        chk("by_timer", WAKE_BY_TIMER, 1);
        chk("boot_done", BOOT_DONE, 1);
        for (i = 0; i < 8; i++) begin
            @(posedge MCLK) RET_ADDR <= 3'(i);
            @(posedge MCLK);
            @(negedge MCLK) chk("ret", RET_RDATA, ret[i]);
        end
        $display("test timer wake done");
        for (i = 0; i < 8; i++) begin
            @(posedge MCLK) CLK_DIV_SEL <= 3'(i);
            clk(256);
            n = 0;
            repeat (128) @(negedge MCLK) n += SYS_CLK_EN;
            chk("sys_clk", n, 128 >> i);
        end
        @(posedge MCLK) PERIPH_OFF <= 8'($random(seed));
        ANALOG_BUSY <= 1'b1;
        clk(2);
        @(negedge MCLK) chk("periph", PERIPH_PWR, 8'(~PERIPH_OFF));
        chk("bandgap", BANDGAP_EN, 1);
        @(posedge MCLK) ANALOG_BUSY <= 1'b0;
        clk(2);
        @(negedge MCLK) chk("bandgap", BANDGAP_EN, 0);
        @(posedge MCLK) TX_REQ <= 1'b1;
        @(posedge MCLK) TX_REQ <= 1'b0;
        for (i = 0; i < 10 && XTAL_EN !== 1'b1; i++) @(negedge MCLK);
        chk("carrier_cal", CARRIER_CAL, 1);
        for (n = 0; n < 1100 && XTAL_EN === 1'b1; n++) @(negedge MCLK);
        chk("xtal_len", n, 1000);
        for (i = 0; i < 10 && PA_EN !== 1'b1; i++) @(negedge MCLK);
        chk("pa", PA_EN, 1);
        chk("div", DIVIDER_EN, 1);
        chk("xtal_off", XTAL_EN, 0);
        chk("cal_off", CARRIER_CAL, 0);
        @(posedge MCLK) TX_END <= 1'b1;
        for (i = 0; i < 10 && CARRIER_OSC_EN !== 1'b0; i++) @(negedge MCLK);
        chk("pa_off", PA_EN, 0);
        @(posedge MCLK) TX_END <= 1'b0;
        $display("test run and tx done");
        @(posedge MCLK) STANDBY_REQ <= 1'b1;
        SLEEP_EN <= 1'b0;
        @(posedge MCLK) STANDBY_REQ <= 1'b0;
        clk(2);
        @(negedge MCLK) chk("osc", LOW_POWER_OSC_EN, 0);
        chk("tick", TIMER_TICK, 0);
        chk("periph", PERIPH_PWR, 0);
        $display("test standby done");
        summarize;
    end
    // cuts a hung run short
    initial begin
        clk(80000);
        n_mismatch++;
        $display("watchdog expired");
        summarize;
    end
endmodule
`default_nettype wire

// ---- logic/retention_ram.sv ----
// eight byte retention memory kept alive through standby
`timescale 1ns/1ps
`default_nettype none
module retention_ram (
    input wire logic clk,
    input wire logic we,
    input wire logic [pwr_seq_pkg::RET_AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_q [pwr_seq_pkg::RET_BYTES];

    // not reset: contents survive resets while the battery stays
    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[addr] <= wdata;
        end
        rdata <= mem_q[addr];
    end
endmodule
`default_nettype wire

// ---- logic/standby_wake_boot_sequencer.sv ----
// power state, wake and boot copy sequencer with clock and power gating
//
// How it works
// - power up lands in standby, not run
// - standby powers all off but retention ram
// - any gpio falling edge starts wake
// - sleep timer expiry wakes the device
// - each wake copies image into ram
// - copy lasts 2 ms plus 3.6 ms/kB, image size capped at 4 kB
// - processor released only after copy done
// - low power osc on except standby
// - system clock divider selects slower rates
// - rtc and timers 2,3 from low_power_osc
// - crystal corrects carrier before tx, then off
// - serializer sequences carrier, divider, pa power
// - power on reset forces defined state
// - bandgap off when no analog block used
`timescale 1ns/1ps
`default_nettype none
module standby_wake_boot_sequencer (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [pwr_seq_pkg::GPIO_N-1:0] GPIO_IN,
    input wire logic [pwr_seq_pkg::TIMER_W-1:0] SLEEP_TICKS,
    input wire logic SLEEP_EN,
    input wire logic STANDBY_REQ,
    input wire logic [2:0] IMAGE_KB,
    output logic [pwr_seq_pkg::RAM_AW-1:0] NVM_ADDR,
    output logic NVM_RD,
    input wire logic [7:0] NVM_DATA,
    output logic [pwr_seq_pkg::RAM_AW-1:0] RAM_ADDR,
    output logic [7:0] RAM_WDATA,
    output logic RAM_WE,
    output logic CPU_RUN_EN,
    output logic BOOT_DONE,
    input wire logic [pwr_seq_pkg::DIV_W-1:0] CLK_DIV_SEL,
    output logic SYS_CLK_EN,
    output logic LOW_POWER_OSC_EN,
    output logic TIMER_TICK,
    input wire logic XTAL_USE,
    input wire logic TX_REQ,
    input wire logic TX_END,
    output logic XTAL_EN,
    output logic CARRIER_CAL,
    output logic CARRIER_OSC_EN,
    output logic DIVIDER_EN,
    output logic PA_EN,
    input wire logic [pwr_seq_pkg::PERIPH_N-1:0] PERIPH_OFF,
    output logic [pwr_seq_pkg::PERIPH_N-1:0] PERIPH_PWR,
    input wire logic ANALOG_BUSY,
    output logic BANDGAP_EN,
    output logic WAKE_BY_TIMER,
    input wire logic RET_WE,
    input wire logic [pwr_seq_pkg::RET_AW-1:0] RET_ADDR,
    input wire logic [7:0] RET_WDATA,
    output logic [7:0] RET_RDATA
);
    pwr_seq_pkg::seq_state_t state_q;
    logic [pwr_seq_pkg::GPIO_N-1:0] gpio_s1_q, gpio_s2_q, gpio_s3_q;
    logic pin_wake;
    logic timer_wake;
    logic [pwr_seq_pkg::TIMER_W-1:0] sleep_cnt_q;
    logic [31:0] wait_cnt_q;
    logic [31:0] wait_len;
    logic [pwr_seq_pkg::RAM_AW:0] copy_idx_q;
    logic [pwr_seq_pkg::RAM_AW:0] copy_len;
    logic rd_pend_q;
    logic [pwr_seq_pkg::DIV_W-1:0] div_sel_q;
    logic [7:0] div_cnt_q;
    logic div_hit;
    logic [15:0] xtal_cnt_q;
    logic [1:0] tx_phase_q;
    logic in_standby;

    assign in_standby = (state_q == pwr_seq_pkg::ST_STANDBY);

    // two flop sync plus history for edge detection
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            gpio_s1_q <= '1;
            gpio_s2_q <= '1;
            gpio_s3_q <= '1;
        end else begin
            gpio_s1_q <= GPIO_IN;
            gpio_s2_q <= gpio_s1_q;
            gpio_s3_q <= gpio_s2_q;
        end
    end

    // any pin going from high to low
    assign pin_wake = |(gpio_s3_q & ~gpio_s2_q);

    // sleep timer counts only in standby
    always_ff @(posedge MCLK) begin
        if (SRST || !in_standby || !SLEEP_EN) begin
            sleep_cnt_q <= pwr_seq_pkg::TIMER_RST;
        end else if (!timer_wake) begin
            sleep_cnt_q <= sleep_cnt_q + 32'h0000_0001;
        end
    end

    assign timer_wake = SLEEP_EN && in_standby && (SLEEP_TICKS != 32'h0000_0000) &&
        (sleep_cnt_q >= SLEEP_TICKS - 32'h0000_0001);

    // length of the copy and of the fixed plus per kilobyte wait
    always_comb begin
        if (IMAGE_KB > 3'h4) begin
            copy_len = 13'(pwr_seq_pkg::RAM_BYTES);
            wait_len = 32'(pwr_seq_pkg::BOOT_FIXED_CYC + 4 * pwr_seq_pkg::BOOT_PER_KB_CYC);
        end else begin
            copy_len = 13'(IMAGE_KB) * 13'(pwr_seq_pkg::KB_BYTES);
            wait_len = 32'(pwr_seq_pkg::BOOT_FIXED_CYC) +
                32'(IMAGE_KB) * 32'(pwr_seq_pkg::BOOT_PER_KB_CYC);
        end
    end

    // main power state sequence
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state_q <= pwr_seq_pkg::ST_STANDBY;
            wait_cnt_q <= 32'h0000_0000;
            WAKE_BY_TIMER <= 1'b0;
        end else begin
            case (state_q)
                pwr_seq_pkg::ST_STANDBY: begin
                    wait_cnt_q <= 32'h0000_0000;
                    if (pin_wake || timer_wake) begin
                        WAKE_BY_TIMER <= timer_wake && !pin_wake;
                        state_q <= pwr_seq_pkg::ST_BOOT_COPY;
                    end
                end
                pwr_seq_pkg::ST_BOOT_COPY: begin
                    wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
                    if (copy_idx_q >= copy_len && !rd_pend_q) begin
                        state_q <= pwr_seq_pkg::ST_BOOT_WAIT;
                    end
                end
                pwr_seq_pkg::ST_BOOT_WAIT: begin
                    wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
                    if (wait_cnt_q >= wait_len - 32'h0000_0001) begin
                        state_q <= pwr_seq_pkg::ST_RUN;
                    end
                end
                pwr_seq_pkg::ST_RUN: begin
                    if (STANDBY_REQ) begin
                        state_q <= pwr_seq_pkg::ST_STANDBY;
                    end else if (TX_REQ) begin
                        state_q <= XTAL_USE ? pwr_seq_pkg::ST_XTAL_CAL : pwr_seq_pkg::ST_TX;
                    end
                end
                pwr_seq_pkg::ST_XTAL_CAL: begin
                    if (xtal_cnt_q >= 16'(pwr_seq_pkg::XTAL_CAL_CYC - 1)) begin
                        state_q <= pwr_seq_pkg::ST_TX;
                    end
                end
                pwr_seq_pkg::ST_TX: begin
                    if (TX_END && tx_phase_q == 2'h0) begin
                        state_q <= pwr_seq_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_q <= pwr_seq_pkg::ST_STANDBY;
                end
            endcase
        end
    end

    // byte copy engine, one read issued, next cycle written
    always_ff @(posedge MCLK) begin
        if (SRST || in_standby) begin
            copy_idx_q <= 13'h0000;
            rd_pend_q <= 1'b0;
            NVM_RD <= 1'b0;
            NVM_ADDR <= 12'h000;
            RAM_WE <= 1'b0;
            RAM_ADDR <= 12'h000;
            RAM_WDATA <= 8'h00;
        end else begin
            RAM_WE <= 1'b0;
            NVM_RD <= 1'b0;
            if (rd_pend_q) begin
                RAM_WE <= 1'b1;
                RAM_ADDR <= NVM_ADDR;
                RAM_WDATA <= NVM_DATA;
                rd_pend_q <= 1'b0;
            end else if (state_q == pwr_seq_pkg::ST_BOOT_COPY && copy_idx_q < copy_len) begin
                NVM_RD <= 1'b1;
                NVM_ADDR <= copy_idx_q[pwr_seq_pkg::RAM_AW-1:0];
                copy_idx_q <= copy_idx_q + 13'h0001;
                rd_pend_q <= 1'b1;
            end
        end
    end

    // processor release and boot flag
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            CPU_RUN_EN <= 1'b0;
            BOOT_DONE <= 1'b0;
        end else begin
            CPU_RUN_EN <= (state_q == pwr_seq_pkg::ST_RUN) || (state_q == pwr_seq_pkg::ST_XTAL_CAL) ||
                (state_q == pwr_seq_pkg::ST_TX);
            BOOT_DONE <= !in_standby && (state_q != pwr_seq_pkg::ST_BOOT_COPY) &&
                (state_q != pwr_seq_pkg::ST_BOOT_WAIT);
        end
    end

    // oscillator gate and programmable system clock enable
    assign div_hit = (div_cnt_q >= (8'h01 << div_sel_q) - 8'h01);
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            LOW_POWER_OSC_EN <= 1'b0;
            div_sel_q <= pwr_seq_pkg::DIV_RST;
            div_cnt_q <= 8'h00;
            SYS_CLK_EN <= 1'b0;
            TIMER_TICK <= 1'b0;
        end else begin
            LOW_POWER_OSC_EN <= !in_standby;
            div_sel_q <= CLK_DIV_SEL;
            TIMER_TICK <= !in_standby;
            if (in_standby || div_hit) begin
                div_cnt_q <= 8'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
            SYS_CLK_EN <= CPU_RUN_EN && div_hit;
        end
    end

    // crystal on only during correction
    always_ff @(posedge MCLK) begin
        if (SRST || state_q != pwr_seq_pkg::ST_XTAL_CAL) begin
            xtal_cnt_q <= 16'h0000;
            XTAL_EN <= 1'b0;
            CARRIER_CAL <= 1'b0;
        end else begin
            xtal_cnt_q <= xtal_cnt_q + 16'h0001;
            XTAL_EN <= 1'b1;
            CARRIER_CAL <= 1'b1;
        end
    end

    // serializer power schedule: carrier, then divider, then pa; off in reverse
    always_ff @(posedge MCLK) begin
        if (SRST || state_q != pwr_seq_pkg::ST_TX) begin
            tx_phase_q <= 2'h0;
            CARRIER_OSC_EN <= 1'b0;
            DIVIDER_EN <= 1'b0;
            PA_EN <= 1'b0;
        end else begin
            if (!TX_END && tx_phase_q != 2'h3) begin
                tx_phase_q <= tx_phase_q + 2'h1;
            end else if (TX_END && tx_phase_q != 2'h0) begin
                tx_phase_q <= tx_phase_q - 2'h1;
            end
            CARRIER_OSC_EN <= (tx_phase_q >= 2'h1) || (!TX_END && tx_phase_q == 2'h0);
            DIVIDER_EN <= (tx_phase_q >= 2'h2);
            PA_EN <= (tx_phase_q == 2'h3);
        end
    end

    // peripheral and bandgap power gates
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            PERIPH_PWR <= '0;
            BANDGAP_EN <= 1'b0;
        end else begin
            PERIPH_PWR <= in_standby ? '0 : ~PERIPH_OFF;
            BANDGAP_EN <= !in_standby && (ANALOG_BUSY || XTAL_EN || CARRIER_OSC_EN);
        end
    end

    // the only storage left alive in standby
    retention_ram u_ret (
        .clk(MCLK),
        .we(RET_WE),
        .addr(RET_ADDR),
        .wdata(RET_WDATA),
        .rdata(RET_RDATA)
    );
endmodule
`default_nettype wire
